// File: logic/kjp_params.svh
`ifndef KJP_PARAMS_SVH
`define KJP_PARAMS_SVH

// Key matrix shape: six drive lines by four sense lines.
`define KJP_ROWS 6
`define KJP_COLS 4
`define KJP_KEYS 24
`define KJP_CODE_W 6
`define KJP_CODE_MAX 6'h3F

// Register byte offsets on the bus.
`define KJP_CTRL_OFS 8'h00
`define KJP_PORTB_OFS 8'h04
`define KJP_KEYS_OFS 8'h08
`define KJP_REF_OFS 8'h0C

// Control register fields and reset value.
`define KJP_CTRL_OVR_BIT 0
`define KJP_CTRL_CODE_LSB 8
`define KJP_CTRL_CODE_MSB 13
`define KJP_CTRL_RESET 7'h00

// Idle and reset levels: row drives released high, senses and comparators high.
`define KJP_PORTA_IDLE 8'hFF
`define KJP_PORTB_RESET 8'hFF
`define KJP_REF_RESET 6'h00

// Read data returned for unmapped offsets and after reset.
`define KJP_RD_ZERO 32'h0000_0000

`endif

// File: logic/kjp_pkg.sv
package kjp_pkg;

    // Value presented on the second port, bit 7 down to bit 0.
    typedef struct packed {
        logic stick1_horizontal_cmp;
        logic stick1_vertical_cmp;
        logic stick2_horizontal_cmp;
        logic stick2_vertical_cmp;
        logic [3:0] column_sense;
    } kjp_portb_type;

    // Software control: an optional reference code that replaces the first port.
    typedef struct packed {
        logic [5:0] code;
        logic override;
    } kjp_ctrl_type;

    // Four joystick axis positions on the reference code scale.
    typedef struct packed {
        logic [5:0] stick1_x;
        logic [5:0] stick1_y;
        logic [5:0] stick2_x;
        logic [5:0] stick2_y;
    } kjp_axes_type;

endpackage

// File: logic/kjp_reader.sv
// Operation
// - Two twelve-key keypads of three by four keys form one matrix of six drives by four senses.
// - The low six bits of the first port, or the control code when override is set, also set the six-bit reference for every axis.
// - An axis bit reads low when the reference code is above the axis and high when below.
// - Second port bit 4 is stick two vertical, 5 stick two horizontal, 6 and 7 stick one.
// - Codes 0 to 63 map monotonically onto the full reference range.
`timescale 1ns/10ps
`include "kjp_params.svh"

module kjp_reader
    import kjp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] PORT_A,
    input wire logic [23:0] KEY_PRESSED,
    input wire logic [5:0] STICK1_X_POS,
    input wire logic [5:0] STICK1_Y_POS,
    input wire logic [5:0] STICK2_X_POS,
    input wire logic [5:0] STICK2_Y_POS,
    output logic [7:0] PORT_B,
    output logic [5:0] REF_LEVEL,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK
);

    // Comparator: high unless the reference code lies above the axis position.
    function automatic logic axis_cmp(input logic [5:0] code, input logic [5:0] pos);
        axis_cmp = (code > pos) ? 1'b0 : 1'b1;
    endfunction

    // Two-stage synchronisers for all pin inputs.
    logic [7:0] a_meta;
    logic [7:0] a_sync;
    logic [23:0] key_meta;
    logic [23:0] key_sync;
    kjp_axes_type axes_meta;
    kjp_axes_type axes_sync;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_meta <= `KJP_PORTA_IDLE;
            a_sync <= `KJP_PORTA_IDLE;
            key_meta <= '0;
            key_sync <= '0;
            axes_meta <= '0;
            axes_sync <= '0;
        end else begin
            a_meta <= PORT_A;
            a_sync <= a_meta;
            key_meta <= KEY_PRESSED;
            key_sync <= key_meta;
            axes_meta <= {STICK1_X_POS, STICK1_Y_POS, STICK2_X_POS, STICK2_Y_POS};
            axes_sync <= axes_meta;
        end
    end

    // Control register and bus interface state.
    kjp_ctrl_type ctrl;
    kjp_ctrl_type next_ctrl;
    logic ack;
    logic next_ack;
    logic [31:0] rd_data;
    logic [31:0] next_rd_data;

    // Effective code on the six low lines: software override or the first port.
    logic [5:0] eff_code;
    assign eff_code = ctrl.override ? ctrl.code : a_sync[5:0];

    // Column senses: a column goes low when any row driven low has a pressed key.
    logic [3:0] sense;
    generate
        for (genvar c = 0; c < `KJP_COLS; c++) begin : g_col
            logic [5:0] hit;
            for (genvar r = 0; r < `KJP_ROWS; r++) begin : g_row
                assign hit[r] = !eff_code[r] && key_sync[r * `KJP_COLS + c];
            end
            assign sense[c] = ~(|hit);
        end
    endgenerate

    // Port and reference outputs.
    kjp_portb_type portb;
    kjp_portb_type next_portb;
    logic [5:0] ref_level;
    logic [5:0] next_ref_level;

    always_comb begin
        next_ref_level = eff_code;
        next_portb.column_sense = sense;
        next_portb.stick2_vertical_cmp = axis_cmp(eff_code, axes_sync.stick2_y);
        next_portb.stick2_horizontal_cmp = axis_cmp(eff_code, axes_sync.stick2_x);
        next_portb.stick1_vertical_cmp = axis_cmp(eff_code, axes_sync.stick1_y);
        next_portb.stick1_horizontal_cmp = axis_cmp(eff_code, axes_sync.stick1_x);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            portb <= `KJP_PORTB_RESET;
            ref_level <= `KJP_REF_RESET;
        end else begin
            portb <= next_portb;
            ref_level <= next_ref_level;
        end
    end

    assign PORT_B = portb;
    assign REF_LEVEL = ref_level;

    // Bus slave: answers every request one cycle later and writes at the acknowledged edge.
    logic req;
    logic wr_now;
    assign req = WB_CYC && WB_STB;
    assign wr_now = req && WB_WE && ack;

    always_comb begin
        next_ack = req && !ack;
        next_ctrl = ctrl;
        next_rd_data = rd_data;
        if (wr_now && WB_ADR == `KJP_CTRL_OFS) begin
            if (WB_SEL[0]) begin
                next_ctrl.override = WB_DAT_I[`KJP_CTRL_OVR_BIT];
            end
            if (WB_SEL[1]) begin
                next_ctrl.code = WB_DAT_I[`KJP_CTRL_CODE_MSB:`KJP_CTRL_CODE_LSB];
            end
        end
        if (req && !ack) begin
            unique case (WB_ADR)
                `KJP_CTRL_OFS: begin
                    next_rd_data = {18'h00000, ctrl.code, 7'h00, ctrl.override};
                end
                `KJP_PORTB_OFS: begin
                    next_rd_data = {24'h000000, portb};
                end
                `KJP_KEYS_OFS: begin
                    next_rd_data = {8'h00, key_sync};
                end
                `KJP_REF_OFS: begin
                    next_rd_data = {26'h0000000, ref_level};
                end
                default: begin
                    next_rd_data = `KJP_RD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= `KJP_CTRL_RESET;
            ack <= 1'b0;
            rd_data <= `KJP_RD_ZERO;
        end else begin
            ctrl <= next_ctrl;
            ack <= next_ack;
            rd_data <= next_rd_data;
        end
    end

    assign WB_ACK = ack;
    assign WB_DAT_O = rd_data;

    // Checks on the behaviour above.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    idle_senses_high_a: assert property (
        key_sync == 24'h000000 |=> portb.column_sense == 4'hF)
        else $error("Column sense low with no key pressed.");

    row_key_low_a: assert property (
        !eff_code[0] && key_sync[0] |=> !portb.column_sense[0])
        else $error("Pressed key in driven row not sensed.");

    ref_tracks_port_a: assert property (
        !ctrl.override |=> ref_level == $past(a_sync[5:0]))
        else $error("Reference does not follow the first port.");

    above_reads_low_a: assert property (
        eff_code > axes_sync.stick1_x |=> !PORT_B[7])
        else $error("Stick one horizontal not low with code above it.");

    below_reads_high_a: assert property (
        eff_code < axes_sync.stick2_y |=> PORT_B[4])
        else $error("Stick two vertical not high with code below it.");

    bit_map_a: assert property (
        1'b1 |=> PORT_B[6] == ($past(eff_code) <= $past(axes_sync.stick1_y))
        && PORT_B[5] == ($past(eff_code) <= $past(axes_sync.stick2_x)))
        else $error("Comparator bits on wrong second-port positions.");

    full_range_a: assert property (
        eff_code == `KJP_CODE_MAX |=> ref_level == `KJP_CODE_MAX)
        else $error("Top code does not reach full reference.");

    ack_once_a: assert property (
        req && !ack |=> ack ##1 !ack)
        else $error("Bus answer not a single cycle pulse.");

    // A write with the code lane disabled must leave the code field alone.
    sel_gates_code_a: assert property (
        wr_now && WB_ADR == `KJP_CTRL_OFS && !WB_SEL[1] |=> ctrl.code == $past(ctrl.code))
        else $error("Code field written with its byte lane disabled.");

    // Main scenarios the bench should reach.
    key_press_c: cover property (!portb.column_sense[3] ##1 portb.column_sense[3]);
    full_scale_c: cover property (ref_level == `KJP_CODE_MAX);
    override_c: cover property (wr_now && WB_DAT_I[`KJP_CTRL_OVR_BIT] ##1 ctrl.override);
    cmp_flip_c: cover property (PORT_B[7] ##1 !PORT_B[7]);

endmodule

// File: tb/kjp_host_model.sv
`timescale 1ns/10ps
// Host side of the parallel ports: port A is an output and port B an input.
module kjp_host_model (
    input wire logic CLK,
    output logic [7:0] port_a,
    input wire logic [7:0] port_b
);
    // Every row drive is released high until the host writes a code.
    initial port_a = 8'hFF;
    // Writes a code, then waits out the sync chain and comparator settling.
    task automatic put(input logic [5:0] code);
        @(posedge CLK);
        port_a <= {2'h3, code};
        repeat (4) @(posedge CLK);
    endtask
    // Successive halving finds the largest code that is not above the axis.
    task automatic find(input int idx, output logic [5:0] pos);
        logic [5:0] trial;
        pos = 6'h00;
        for (int b = 5; b >= 0; b--) begin
            trial = pos | (6'h01 << b);
            put(trial);
            if (port_b[idx] === 1'b1) begin
                pos = trial;
            end
        end
    endtask
endmodule

// File: tb/tb_kjp_reader.sv
`timescale 1ns/10ps
module tb_kjp_reader;
    import kjp_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [23:0] keys = 24'h000000;
    kjp_axes_type axes = {6'h2A, 6'h05, 6'h3F, 6'h00};
    logic cyc = 1'b0;
    logic [3:0] sel = 4'hF;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic ack;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [5:0] ref_level;
    logic [5:0] pos;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [5:0] row_code [3] = '{6'h3E, 6'h1F, 6'h00};
    logic [23:0] row_keys [3] = '{24'h000002, 24'h800002, 24'h000041};
    logic [7:0] row_exp [3] = '{8'h2D, 8'hA7, 8'hFA};

    kjp_reader dut (.CLK(CLK), .RST_N(RST_N), .PORT_A(port_a), .KEY_PRESSED(keys),
        .STICK1_X_POS(axes.stick1_x), .STICK1_Y_POS(axes.stick1_y),
        .STICK2_X_POS(axes.stick2_x), .STICK2_Y_POS(axes.stick2_y),
        .PORT_B(port_b), .REF_LEVEL(ref_level), .WB_CYC(cyc), .WB_STB(cyc), .WB_WE(we),
        .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK(ack));
    kjp_host_model host (.CLK(CLK), .port_a(port_a), .port_b(port_b));

    // The clock toggles every half period of 2.5 ns, a period of 5 ns.
    initial forever #2.5 CLK = ~CLK;

    // Compares one observed value with its expectation and counts both.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic bus cycle held until ack is seen at a rising edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        @(posedge CLK);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge CLK);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    // Expected second port from the key matrix and the comparator rules.
    function automatic logic [7:0] exp_b(input logic [5:0] c);
        logic [3:0] col;
        col = 4'hF;
        for (int r = 0; r < 6; r++)
            for (int k = 0; k < 4; k++)
                if (!c[r] && keys[r * 4 + k]) col[k] = 1'b0;
        return {c <= axes.stick1_x, c <= axes.stick1_y, c <= axes.stick2_x,
            c <= axes.stick2_y, col};
    endfunction
    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge CLK);
        chk("reset port_b", port_b, 8'hFF);
        chk("reset ref", ref_level, 6'h00);
        RST_N <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", rdat, 32'h0);
        for (int i = 0; i < 3; i++) begin
            keys <= row_keys[i];
            host.put(row_code[i]);
            chk("row port_b", port_b, row_exp[i]);
        end
        keys <= 24'h000010;
        for (int c = 0; c < 64; c++) begin
            host.put(c[5:0]);
            chk("sweep port_b", port_b, exp_b(c[5:0]));
            chk("sweep ref", ref_level, c[5:0]);
        end
        for (int i = 4; i < 8; i++) begin
            host.find(i, pos);
            chk("axis search", pos, axes[(i - 4) * 6 +: 6]);
        end
        wb(1'b1, 8'h00, 32'h0000_1501);
        repeat (2) @(posedge CLK);
        chk("override ref", ref_level, 6'h15);
        chk("override port_b", port_b, exp_b(6'h15));
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl read", rdat, 32'h0000_1501);
        wb(1'b0, 8'h0C, 32'h0);
        chk("ref read", rdat, 32'h0000_0015);
        wb(1'b0, 8'h04, 32'h0);
        chk("portb read", rdat, {24'h0, exp_b(6'h15)});
        wb(1'b0, 8'h08, 32'h0);
        chk("keys read", rdat, 32'h0000_0010);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped read", rdat, 32'h0);
        RST_N <= 1'b0;
        @(posedge CLK);
        chk("mid reset port_b", port_b, 8'hFF);
        RST_N <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl after reset", rdat, 32'h0);
        wb(1'b1, 8'h00, 32'h0000_2A01, 4'h1);
        wb(1'b0, 8'h00, 32'h0);
        chk("sel gated ctrl", rdat, 32'h0000_0001);
        repeat (3) @(posedge CLK);
        chk("sel gated ref", ref_level, 6'h00);
        chk("sel gated port_b", port_b, exp_b(6'h00));
        finish_test();
    end
endmodule
